/* verilog/acsd_pkg.sv */
// Shared constants and state types for the converter command decoder and its host.
package acsd_pkg;

    // Command byte layout.
    localparam int OP_MSB = 7;
    localparam int OP_LSB = 5;
    localparam int AINC_BIT = 4;
    localparam int PTR_MSB = 3;

    // Operation codes.
    localparam logic [2:0] OP_DIRECT0 = 3'h0;
    localparam logic [2:0] OP_RDATA = 3'h1;
    localparam logic [2:0] OP_RREG = 3'h2;
    localparam logic [2:0] OP_WREG = 3'h3;
    localparam logic [2:0] OP_CONVERT = 3'h4;
    localparam logic [2:0] OP_RSVD = 3'h5;
    localparam logic [2:0] OP_RESET = 3'h6;
    localparam logic [2:0] OP_DIRECT1 = 3'h7;

    // Register map: addresses 00h to 08h are writable, 09h is the identity register.
    localparam logic [3:0] REG_LAST = 4'h9;
    localparam logic [71:0] REG_RST = {8'h00, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00,
                                       8'h83, 8'h0A};
    localparam logic [7:0] ID_RST = 8'h5A; // Arbitrary identity value.
    localparam int CFG0_STAT_BIT = 1;
    localparam int CFG0_TMO_BIT = 6;

    // Status byte layout.
    localparam int ST_NEW = 7;
    localparam int ST_OVR = 6;
    localparam int ST_SUP = 5;

    // Idle-clock timeout counts in master clock cycles.
    localparam int TMO_LONG = 4096;
    localparam int TMO_SHORT = 256;
    localparam logic [1:0] ABORT_CYCLES = 2'h2;

    // Over-range limit: 1.06 times full scale, with full scale at 2 to the 23rd codes.
    localparam int OVR_LIMIT = 8891924;
    localparam logic [23:0] FS_POS = 24'h7FFFFF;
    localparam logic [23:0] FS_NEG = 24'h800000;

    // Supply monitor trip point and hysteresis in millivolts.
    localparam logic [12:0] SUP_TRIP_MV = 13'h10CC;
    localparam logic [12:0] SUP_HYST_MV = 13'h0032;

    // Channel tags.
    localparam int TAG_COUNT = 30;
    localparam logic [4:0] TAG_RESERVED = 5'h19;
    localparam logic [4:0] TAG_LAST = 5'h1D;

    // Host serial clock half period in master clock cycles.
    localparam int HOST_HALF = 4;

    // Device link states.
    typedef enum logic [4:0] {
        LS_CMD = 5'h01,
        LS_DIRECT = 5'h02,
        LS_RDATA = 5'h04,
        LS_RREG = 5'h08,
        LS_WREG = 5'h10
    } acsd_lstate_e;

    // Host states.
    typedef enum logic [3:0] {
        HS_IDLE = 4'h1,
        HS_SETUP = 4'h2,
        HS_SHIFT = 4'h4,
        HS_GAP = 4'h8
    } acsd_hstate_e;

endpackage

/* verilog/acsd_link_if.sv */
// Serial link between the command decoder device and its host.
`timescale 1ns/1ns
interface acsd_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    modport dev (input sclk, input cs_n, input mosi, output miso);
    modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

/* verilog/acsd_dev.sv */
// Device end: command decoder, register file and result word composer.
`timescale 1ns/1ns
// Function
// RULE_01 - Over-range beyond 1.06 reference flags and saturates
// RULE_02 - Low supply flag with hysteresis
// RULE_03 - Channel tag undefined in fixed mode
// RULE_04 - 24-bit two's complement result, MSB first
// RULE_05 - Auto-scan tags identify pairs and single inputs
// RULE_06 - Scan enabled channels in ascending tag order
// RULE_07 - Command byte: opcode, increment flag, pointer
// RULE_08 - 000/111 direct read, then reset link
// RULE_09 - 001 register-format read with status byte
// RULE_10 - 010 reads, 011 writes configuration registers
// RULE_11 - 100 convert pulse, 110 converter reset
// RULE_12 - Increment flag advances pointer per byte
// RULE_13 - Increment access ends after address 09h
// RULE_14 - Chip select or idle clock resets link
// RULE_15 - Commands may follow back to back
// RULE_16 - Register data bytes follow command immediately
// RULE_17 - Over-range flag sent with sign bit
// RULE_18 - Fresh flag set on new, cleared on reread
// RULE_19 - Status enable picks four or three bytes; direct reads of results taken in fixed mode always give three
// RULE_20 - Reserved opcode 101 does nothing
// RULE_21 - Tag 19h never emitted
module acsd_dev
    import acsd_pkg::*;
#(
    parameter int TMO_LONG_CYC = TMO_LONG,
    parameter int TMO_SHORT_CYC = TMO_SHORT,
    parameter int SMP_W = 26,
    parameter logic [7:0] ID_VALUE = ID_RST
) (
    // Core clock, reset and enable.
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // Serial link.
    acsd_link_if.dev lnk,
    // Converter side.
    input wire logic sample_valid_in,
    input wire logic signed [SMP_W-1:0] sample_in,
    input wire logic [12:0] supply_mv_in,
    input wire logic fixed_mode_in,
    input wire logic [TAG_COUNT-1:0] scan_mask_in,
    // Results and control events.
    output logic [23:0] result_out,
    output logic [7:0] status_out,
    output logic convert_out,
    output logic adc_reset_out
);

    // Finds the next enabled tag above cur, wrapping, never the reserved one.
    function automatic logic [4:0] next_tag(input logic [4:0] cur,
                                            input logic [TAG_COUNT-1:0] m);
        logic [4:0] t;
        logic [4:0] r;
        logic hit;
        t = cur;
        r = cur;
        hit = 1'b0;
        for (int i = 0; i < TAG_COUNT; i++) begin
            t = (t == TAG_LAST) ? 5'h00 : t + 5'h01;
            if (!hit && m[t] && t != TAG_RESERVED) begin // RULE_06 RULE_21
                r = t;
                hit = 1'b1;
            end
        end
        return r;
    endfunction

    // ---------------- Core domain ----------------
    logic rst_q;
    logic [2:0] sclk_sy_q;
    logic [1:0] cs_sy_q;
    logic [1:0] tsel_sy_q;
    logic [2:0] conv_sy_q;
    logic [2:0] rcmd_sy_q;
    logic [12:0] tmo_q;
    logic [1:0] abort_cnt_q;
    logic abort_q;
    logic [4:0] tag_q;
    logic sup_q;
    logic [31:0] hold_q;
    logic res_tgl_q;
    // Link-domain state read by the core through synchronisers.
    logic conv_tgl_q;
    logic rcmd_tgl_q;
    logic [7:0] regs_q [9];

    // Idle timeout limit and activity seen on the synchronised chip select and link clock.
    wire link_busy = cs_sy_q[1] || (sclk_sy_q[2] ^ sclk_sy_q[1]);
    wire [12:0] tmo_lim = tsel_sy_q[1] ? 13'(TMO_SHORT_CYC) : 13'(TMO_LONG_CYC);
    wire tmo_fire = !link_busy && (tmo_q == tmo_lim - 13'h0001);

    // Result shaping: over-range detection and saturation.
    wire signed [SMP_W-1:0] smp_abs = sample_in[SMP_W-1] ? -sample_in : sample_in;
    wire smp_ovr = smp_abs > SMP_W'(OVR_LIMIT); // RULE_01
    wire smp_hi = !sample_in[SMP_W-1] && (sample_in > SMP_W'($signed(FS_POS)));
    wire smp_lo = sample_in[SMP_W-1] && (sample_in < SMP_W'($signed(FS_NEG)));
    wire [23:0] smp_data = smp_hi ? FS_POS : (smp_lo ? FS_NEG : sample_in[23:0]); // RULE_01
    wire [4:0] smp_tag = fixed_mode_in ? 5'h00 : tag_q; // RULE_03 RULE_05

    // Synchronisers and reset flop for the link domain.
    always_ff @(posedge clk_in) begin
        rst_q <= rst_in;
        if (clk_en_in) begin
            sclk_sy_q <= {sclk_sy_q[1:0], lnk.sclk};
            cs_sy_q <= {cs_sy_q[0], lnk.cs_n};
            tsel_sy_q <= {tsel_sy_q[0], regs_q[0][CFG0_TMO_BIT]};
            conv_sy_q <= {conv_sy_q[1:0], conv_tgl_q};
            rcmd_sy_q <= {rcmd_sy_q[1:0], rcmd_tgl_q};
        end
    end

    // Idle-clock watchdog that aborts the link for a short time.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tmo_q <= 13'h0000;
            abort_cnt_q <= 2'h0;
            abort_q <= 1'b0;
        end else if (clk_en_in) begin
            if (link_busy) begin
                tmo_q <= 13'h0000;
            end else if (tmo_q != tmo_lim) begin
                tmo_q <= tmo_q + 13'h0001;
            end
            if (tmo_fire) begin // RULE_14
                abort_cnt_q <= ABORT_CYCLES;
                abort_q <= 1'b1;
            end else if (abort_cnt_q != 2'h0) begin
                abort_cnt_q <= abort_cnt_q - 2'h1;
                abort_q <= (abort_cnt_q != 2'h1);
            end
        end
    end

    // Result capture, scan tag, supply flag and event outputs.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tag_q <= 5'h00;
            sup_q <= 1'b0;
            hold_q <= 32'h00000000;
            res_tgl_q <= 1'b0;
            result_out <= 24'h000000;
            status_out <= 8'h00;
            convert_out <= 1'b0;
            adc_reset_out <= 1'b0;
        end else if (clk_en_in) begin
            convert_out <= conv_sy_q[2] ^ conv_sy_q[1]; // RULE_11
            adc_reset_out <= rcmd_sy_q[2] ^ rcmd_sy_q[1]; // RULE_11
            if (supply_mv_in < SUP_TRIP_MV) begin // RULE_02
                sup_q <= 1'b1;
            end else if (supply_mv_in >= SUP_TRIP_MV + SUP_HYST_MV) begin
                sup_q <= 1'b0;
            end
            if (adc_reset_out) begin
                tag_q <= next_tag(TAG_LAST, scan_mask_in);
            end else if (sample_valid_in) begin
                hold_q <= {fixed_mode_in, smp_ovr, sup_q, smp_tag, smp_data}; // RULE_17
                res_tgl_q <= ~res_tgl_q;
                result_out <= smp_data;
                status_out <= {1'b1, smp_ovr, sup_q, smp_tag};
                tag_q <= next_tag(tag_q, scan_mask_in); // RULE_06
            end
        end
    end

    // ---------------- Link domain ----------------
    acsd_lstate_e st_q;
    logic [2:0] bcnt_q;
    logic [7:0] sh_q;
    logic [31:0] osr_q;
    logic first_q;
    logic [3:0] ptr_q;
    logic mul_q;
    logic [1:0] bytes_q;
    logic [2:0] res_sy_q;
    logic [31:0] res_q;
    logic new_q;

    // Register read mux; the identity register sits at the last address.
    function automatic logic [7:0] reg_rd(input logic [3:0] a, input logic [7:0] r [9]);
        reg_rd = (a == REG_LAST) ? ID_VALUE : ((a < REG_LAST) ? r[a] : 8'h00);
    endfunction

    // Byte assembly and command decode.
    wire link_clr = rst_q | lnk.cs_n | abort_q; // RULE_14
    wire [7:0] byte_nx = {sh_q[6:0], lnk.mosi};
    wire byte_end = bcnt_q == 3'h7;
    wire [2:0] op_w = byte_nx[OP_MSB:OP_LSB]; // RULE_07
    wire cmd_end = (st_q == LS_CMD) && byte_end;
    wire early_dir = (st_q == LS_CMD) && (bcnt_q == 3'h2)
                     && (byte_nx[2:0] == OP_DIRECT0 || byte_nx[2:0] == OP_DIRECT1); // RULE_08
    wire reg_end = (st_q == LS_RREG || st_q == LS_WREG) && byte_end;
    wire adv = reg_end && mul_q && (ptr_q != REG_LAST); // RULE_12 RULE_13
    wire wr_en = (st_q == LS_WREG) && byte_end && (ptr_q < REG_LAST); // RULE_10
    wire rst_cmd = cmd_end && (op_w == OP_RESET); // RULE_11
    wire conv_cmd = cmd_end && (op_w == OP_CONVERT); // RULE_11
    wire new_clr = early_dir || (cmd_end && op_w == OP_RDATA); // RULE_18
    wire res_new = res_sy_q[2] ^ res_sy_q[1];
    wire rd_done = byte_end && (!mul_q || bytes_q == 2'h3); // RULE_09

    // Result word shapes for the two read formats.
    wire [7:0] status_w = {new_q, res_q[30:24]};
    wire stat_en = regs_q[0][CFG0_STAT_BIT] && !res_q[31]; // RULE_19
    wire [31:0] dir_word = stat_en ? {status_w, res_q[23:0]} : {res_q[23:0], 8'h00};
    wire [31:0] osr_sh = first_q ? {dir_word[30:0], 1'b0} : {osr_q[30:0], 1'b0};
    assign lnk.miso = first_q ? dir_word[31] : osr_q[31]; // RULE_04

    // Frame sequencer; cleared by chip select, the watchdog or reset.
    always_ff @(posedge lnk.sclk or posedge link_clr) begin
        if (link_clr) begin
            st_q <= LS_CMD;
            bcnt_q <= 3'h0;
            sh_q <= 8'h00;
            osr_q <= 32'h00000000;
            first_q <= 1'b1;
            ptr_q <= 4'h0;
            mul_q <= 1'b0;
            bytes_q <= 2'h0;
        end else begin
            first_q <= 1'b0;
            bcnt_q <= bcnt_q + 3'h1;
            sh_q <= byte_nx;
            osr_q <= osr_sh; // RULE_04
            if (early_dir) begin
                st_q <= LS_DIRECT;
            end
            if (cmd_end) begin // RULE_15
                mul_q <= byte_nx[AINC_BIT];
                ptr_q <= byte_nx[PTR_MSB:0];
                bytes_q <= 2'h0;
                case (op_w)
                    OP_RDATA: begin // RULE_09
                        st_q <= LS_RDATA;
                        osr_q <= {status_w, res_q[23:0]};
                    end
                    OP_RREG: begin // RULE_16
                        st_q <= LS_RREG;
                        osr_q <= {reg_rd(byte_nx[PTR_MSB:0], regs_q), 24'h000000};
                    end
                    OP_WREG: st_q <= LS_WREG; // RULE_16
                    default: osr_q <= dir_word; // RULE_20
                endcase
            end
            if (st_q == LS_RDATA && byte_end) begin
                bytes_q <= bytes_q + 2'h1;
                if (rd_done) begin
                    st_q <= LS_CMD;
                    osr_q <= dir_word;
                end
            end
            if (reg_end) begin
                if (adv) begin // RULE_12
                    ptr_q <= ptr_q + 4'h1;
                    osr_q <= {reg_rd(ptr_q + 4'h1, regs_q), 24'h000000};
                end else begin // RULE_13
                    st_q <= LS_CMD;
                    osr_q <= dir_word;
                end
            end
        end
    end

    // Registers, result hand-off and event toggles; kept across frames.
    always_ff @(posedge lnk.sclk or posedge rst_q) begin
        if (rst_q) begin
            for (int i = 0; i < 9; i++) begin
                regs_q[i] <= REG_RST[8*i +: 8];
            end
            res_sy_q <= 3'h0;
            res_q <= 32'h00000000;
            new_q <= 1'b0;
            conv_tgl_q <= 1'b0;
            rcmd_tgl_q <= 1'b0;
        end else begin
            res_sy_q <= {res_sy_q[1:0], res_tgl_q};
            if (rst_cmd) begin
                for (int i = 0; i < 9; i++) begin
                    regs_q[i] <= REG_RST[8*i +: 8];
                end
            end else if (wr_en) begin
                regs_q[ptr_q] <= byte_nx; // RULE_10
            end
            if (res_new) begin // RULE_18
                res_q <= hold_q;
                new_q <= 1'b1;
            end else if (new_clr) begin
                new_q <= 1'b0;
            end
            if (conv_cmd) begin
                conv_tgl_q <= ~conv_tgl_q;
            end
            if (rst_cmd) begin
                rcmd_tgl_q <= ~rcmd_tgl_q;
            end
        end
    end

endmodule // acsd_dev

/* verilog/acsd_host.sv */
// Host end: drives command and data bytes over the serial link.
`timescale 1ns/1ns
module acsd_host
    import acsd_pkg::*;
#(
    parameter int HALF_CYC = HOST_HALF
) (
    // Clock, reset and enable.
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // Serial link.
    acsd_link_if.host lnk,
    // Transaction request.
    input wire logic start_in,
    output logic ready_out,
    input wire logic [7:0] cmd_in,
    input wire logic [31:0] tx_in,
    input wire logic [2:0] nbytes_in,
    input wire logic keep_cs_in,
    // Transaction answer.
    output logic [31:0] rx_out,
    output logic done_out
);

    acsd_hstate_e st_q;
    logic [7:0] div_q;
    logic [5:0] bits_q;
    logic [5:0] total_q;
    logic [39:0] sh_q;
    logic sclk_q;
    logic cs_n_q;
    logic mosi_q;
    logic keep_q;
    logic [1:0] miso_sy_q;

    // Command shaping and divider tick.
    wire is_rdata = cmd_in[OP_MSB:OP_LSB] == OP_RDATA;
    wire is_dir = cmd_in[OP_MSB:OP_LSB] == OP_DIRECT0 || cmd_in[OP_MSB:OP_LSB] == OP_DIRECT1;
    wire [7:0] cmd_fix = {cmd_in[7:5], cmd_in[AINC_BIT] | is_rdata, cmd_in[3:0]}; // RULE_09
    wire tick = div_q == 8'(HALF_CYC - 1);
    assign ready_out = st_q == HS_IDLE;
    assign lnk.sclk = sclk_q;
    assign lnk.cs_n = cs_n_q;
    assign lnk.mosi = mosi_q;

    // Returned data is synchronised before sampling.
    always_ff @(posedge clk_in) begin
        if (clk_en_in) begin
            miso_sy_q <= {miso_sy_q[0], lnk.miso};
        end
    end

    // Transaction sequencer with the serial clock divider.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= HS_IDLE;
            div_q <= 8'h00;
            bits_q <= 6'h00;
            total_q <= 6'h00;
            sh_q <= 40'h0000000000;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            mosi_q <= 1'b0;
            keep_q <= 1'b0;
            rx_out <= 32'h00000000;
            done_out <= 1'b0;
        end else if (clk_en_in) begin
            done_out <= 1'b0;
            div_q <= tick ? 8'h00 : div_q + 8'h01;
            case (st_q)
                HS_IDLE: begin
                    div_q <= 8'h00;
                    if (start_in) begin // RULE_15
                        sh_q <= {cmd_fix, tx_in}; // RULE_07
                        total_q <= 6'h08 + {nbytes_in, 3'h0}; // RULE_16
                        bits_q <= 6'h00;
                        keep_q <= keep_cs_in && !is_dir; // RULE_08
                        cs_n_q <= 1'b0;
                        st_q <= HS_SETUP;
                    end
                end
                HS_SETUP: begin
                    if (tick) begin
                        mosi_q <= sh_q[39];
                        st_q <= HS_SHIFT;
                    end
                end
                HS_SHIFT: begin
                    if (tick && !sclk_q) begin
                        sclk_q <= 1'b1;
                        rx_out <= {rx_out[30:0], miso_sy_q[1]};
                        bits_q <= bits_q + 6'h01;
                    end else if (tick) begin
                        sclk_q <= 1'b0;
                        if (bits_q == total_q) begin // RULE_14
                            done_out <= 1'b1;
                            mosi_q <= 1'b0;
                            cs_n_q <= !keep_q;
                            st_q <= keep_q ? HS_IDLE : HS_GAP;
                        end else begin
                            sh_q <= {sh_q[38:0], 1'b0};
                            mosi_q <= sh_q[38];
                        end
                    end
                end
                HS_GAP: begin
                    if (tick) begin
                        st_q <= HS_IDLE;
                    end
                end
                default: st_q <= HS_IDLE;
            endcase
        end
    end

endmodule // acsd_host

/* verif/acsd_link_assertions.sv */
// Concurrent checks on the decoder's link framing and result side.
`timescale 1ns/1ns
module acsd_assertions
    import acsd_pkg::*;
#(
    parameter int SMP_W = 26
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // Link signals.
    input wire logic sclk,
    input wire logic cs_n,
    // Converter side of the device.
    input wire logic clk_en_in,
    input wire logic sample_valid_in,
    input wire logic signed [SMP_W-1:0] sample_in,
    input wire logic [12:0] supply_mv_in,
    input wire logic [23:0] result_out,
    input wire logic [7:0] status_out,
    input wire logic convert_out,
    input wire logic adc_reset_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // An accepted sample, and a supply level held long enough for the monitor.
    sequence s_take;
        sample_valid_in && clk_en_in && !adc_reset_out;
    endsequence
    sequence s_sup_steady;
        $stable(supply_mv_in) && $past(supply_mv_in, 2) == supply_mv_in;
    endsequence

    // Result word, flags, event pulses and the clock outside a frame.
    property p_ovr_pos;
        s_take ##0 (sample_in > OVR_LIMIT) |=> result_out == FS_POS && status_out[ST_OVR];
    endproperty
    a_ovr_pos: assert property (p_ovr_pos) else $error("positive overrange not clipped");
    property p_ovr_neg;
        s_take ##0 (sample_in < -OVR_LIMIT) |=> result_out == FS_NEG && status_out[ST_OVR];
    endproperty
    a_ovr_neg: assert property (p_ovr_neg) else $error("negative overrange not clipped");
    property p_in_range;
        s_take ##0 (sample_in < 8388608 && sample_in >= -8388608)
            |=> result_out == $past(sample_in[23:0]) && !status_out[ST_OVR];
    endproperty
    a_in_range: assert property (p_in_range) else $error("in-range result altered");
    property p_sup_low;
        s_take ##0 s_sup_steady ##0 (supply_mv_in < SUP_TRIP_MV) |=> status_out[ST_SUP];
    endproperty
    a_sup_low: assert property (p_sup_low) else $error("low supply not flagged");
    property p_sup_high;
        s_take ##0 s_sup_steady ##0 (supply_mv_in >= SUP_TRIP_MV + SUP_HYST_MV)
            |=> !status_out[ST_SUP];
    endproperty
    a_sup_high: assert property (p_sup_high) else $error("supply flag not cleared");
    property p_no_tag19;
        status_out[4:0] != TAG_RESERVED;
    endproperty
    a_no_tag19: assert property (p_no_tag19) else $error("unassigned tag shown");
    property p_conv_pulse;
        $rose(convert_out) |-> !$past(cs_n, 2) ##1 !convert_out;
    endproperty
    a_conv_pulse: assert property (p_conv_pulse) else $error("bad convert pulse");
    property p_rst_pulse;
        $rose(adc_reset_out) |-> !$past(cs_n, 2) ##1 !adc_reset_out;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("bad reset pulse");
    property p_idle_clock;
        cs_n |-> !sclk;
    endproperty
    a_idle_clock: assert property (p_idle_clock) else $error("clock outside frame");
endmodule // acsd_assertions

/* verif/acsd_tb.sv */
// Self-checking bench joining the host and device ends over the link.
`timescale 1ns/1ns
module acsd_tb;
    import acsd_pkg::*;
    localparam int TMO_L = 64;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic en = 1'b1;
    logic start = 1'b0;
    logic keep = 1'b0;
    logic smp_v = 1'b0;
    logic signed [25:0] smp = '0;
    logic [12:0] sup = 13'h1388;
    logic [7:0] cmd = '0;
    logic [31:0] tx = '0;
    logic [2:0] nb = '0;
    logic ready, done, conv, arst;
    logic [31:0] rx;
    logic [23:0] result;
    logic [7:0] status;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    int n_conv = 0;
    int n_arst = 0;

    // Both ends meet over one link.
    acsd_link_if i_acsd_link_if ();
    acsd_dev #(.TMO_LONG_CYC(TMO_L), .TMO_SHORT_CYC(16)) i_acsd_dev (
        .clk_in(clk_in), .rst_in(rst_in), .clk_en_in(en), .lnk(i_acsd_link_if.dev),
        .sample_valid_in(smp_v), .sample_in(smp), .supply_mv_in(sup), .fixed_mode_in(1'b0),
        .scan_mask_in('1), .result_out(result), .status_out(status), .convert_out(conv),
        .adc_reset_out(arst));
    acsd_host i_acsd_host (
        .clk_in(clk_in), .rst_in(rst_in), .clk_en_in(en), .lnk(i_acsd_link_if.host),
        .start_in(start), .ready_out(ready), .cmd_in(cmd), .tx_in(tx), .nbytes_in(nb),
        .keep_cs_in(keep), .rx_out(rx), .done_out(done));
    acsd_assertions #(.SMP_W(26)) i_acsd_assertions (
        .clk_in(clk_in), .rst_in(rst_in), .sclk(i_acsd_link_if.sclk),
        .cs_n(i_acsd_link_if.cs_n), .clk_en_in(en), .sample_valid_in(smp_v),
        .sample_in(smp), .supply_mv_in(sup), .result_out(result), .status_out(status),
        .convert_out(conv), .adc_reset_out(arst));

    // Clock, event counters and the hang limit.
    always #50 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc++;
        if (conv === 1'b1) n_conv++;
        if (arst === 1'b1) n_arst++;
        if (cyc == 30000) begin
            failures++;
            finish_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One host transaction, waited for under a bounded count.
    task automatic xfer(input logic [7:0] c, input logic [31:0] d, input logic [2:0] n,
                        input logic k);
        int w;
        w = 0;
        @(negedge clk_in);
        cmd = c;
        tx = d;
        nb = n;
        keep = k;
        start = 1'b1;
        @(negedge clk_in);
        start = 1'b0;
        while (done !== 1'b1 && w < 3000) begin
            @(negedge clk_in);
            w++;
        end
        while (ready !== 1'b1 && w < 3000) begin
            @(negedge clk_in);
            w++;
        end
        chk("transfer completion", w < 3000, 1'b1);
    endtask

    task automatic rd(input logic [3:0] p, input logic [2:0] n, input logic [31:0] exp);
        logic [31:0] m;
        m = (n == 3'h4) ? 32'hFFFFFFFF : ((32'h1 << (8 * n)) - 32'h1);
        xfer({OP_RREG, 1'b1, p}, 32'h0, n, 1'b0);
        chk("register read", rx & m, exp);
    endtask

    task automatic t_regs();
        int c0;
        c0 = n_conv;
        rd(4'h0, 3'h4, 32'h0A830000);
        rd(4'h6, 3'h4, {24'h00FF00, ID_RST});
        xfer({OP_WREG, 1'b1, 4'h8}, 32'h11229F00, 3'h3, 1'b0);
        chk("convert after last register", n_conv, c0 + 1);
        rd(4'h8, 3'h2, {16'h0011, ID_RST});
        xfer({OP_WREG, 1'b0, 4'h2}, 32'h33330000, 3'h2, 1'b0);
        rd(4'h2, 3'h2, 32'h00003300);
        $display("test registers done");
    endtask

    task automatic t_ops();
        int c0;
        int r0;
        c0 = n_conv;
        r0 = n_arst;
        xfer(8'hBF, 32'h0, 3'h0, 1'b0);
        chk("events after reserved code", n_conv + n_arst, c0 + r0);
        rd(4'h2, 3'h1, 32'h33);
        xfer(8'h9F, 32'h0, 3'h0, 1'b1);
        xfer(8'h80, 32'h0, 3'h0, 1'b0);
        chk("back to back converts", n_conv, c0 + 2);
        xfer(8'hD5, 32'h0, 3'h0, 1'b0);
        chk("converter resets", n_arst, r0 + 1);
        rd(4'h2, 3'h1, 32'h0);
        $display("test commands done");
    endtask

    task automatic t_data();
        logic [25:0] sv [6] = '{26'h0123456, 26'h087AE14, 26'h087AE15, 26'h376ABC0,
                                26'h3800000, 26'h3FFFFFF};
        logic [23:0] rv [6] = '{24'h123456, 24'h7FFFFF, 24'h7FFFFF, 24'h800000,
                                24'h800000, 24'hFFFFFF};
        logic [12:0] su [6] = '{13'h1388, 13'h10CB, 13'h10E0, 13'h10FD, 13'h10FE, 13'h1388};
        logic [5:0] ov = 6'b001100;
        logic [5:0] sf = 6'b011100;
        for (int i = 0; i < 6; i++) begin
            @(negedge clk_in);
            sup = su[i];
            repeat (2) @(negedge clk_in);
            smp = sv[i];
            smp_v = 1'b1;
            @(negedge clk_in);
            smp_v = 1'b0;
            @(negedge clk_in);
            chk("result", result, rv[i]);
            chk("overrange flag", status[ST_OVR], ov[5 - i]);
            chk("supply flag", status[ST_SUP], sf[5 - i]);
            chk("channel tag", status[4:0], i);
            // A reserved command clocks the link so that it picks up each sample.
            xfer(8'hA0, 32'h0, 3'h0, 1'b0);
        end
        xfer(8'h30, 32'h0, 3'h4, 1'b0);
        chk("register format read", {rx[31:29], rx[23:0]}, {3'h4, 24'hFFFFFF});
        xfer(8'h30, 32'h0, 3'h4, 1'b0);
        chk("repeated read", {rx[31:29], rx[23:0]}, {3'h0, 24'hFFFFFF});
        xfer(8'h00, 32'h0, 3'h3, 1'b0);
        chk("direct read zero code", {rx[30:29], rx[23:0]}, {2'h0, 24'hFFFFFF});
        xfer(8'hE0, 32'h0, 3'h3, 1'b0);
        chk("direct read ones code", {rx[30:29], rx[23:0]}, {2'h0, 24'hFFFFFF});
        // With the status byte disabled a direct read returns the data bytes only.
        xfer({OP_WREG, 1'b0, 4'h0}, 32'h08000000, 3'h1, 1'b0);
        xfer(8'h00, 32'h0, 3'h3, 1'b0);
        chk("data only read", rx, 32'hFFFFFF00);
        $display("test data done");
    endtask

    task automatic t_tmo();
        int c0;
        c0 = n_conv;
        // Convert bytes inside a direct read frame must be ignored.
        xfer(8'h00, 32'h9F9F9F9F, 3'h4, 1'b0);
        chk("command ignored after direct read", n_conv, c0);
        // A write left open with the clock idle is ended by the long watchdog.
        xfer({OP_WREG, 1'b1, 4'h1}, 32'h47000000, 3'h1, 1'b1);
        repeat (TMO_L + 16) @(negedge clk_in);
        xfer(8'h9F, 32'h0, 3'h0, 1'b1);
        chk("command after idle timeout", n_conv, c0 + 1);
        rd(4'h1, 3'h2, 32'h4700);
        // The short watchdog fires well before the long one would.
        xfer({OP_WREG, 1'b1, 4'h0}, 32'h4A470000, 3'h2, 1'b1);
        repeat (24) @(negedge clk_in);
        xfer(8'h9F, 32'h0, 3'h0, 1'b0);
        chk("command after short timeout", n_conv, c0 + 2);
        $display("test timeout done");
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Reset, then the scenarios in turn.
    initial begin
        repeat (5) @(negedge clk_in);
        rst_in = 1'b0;
        t_regs();
        t_ops();
        t_data();
        t_tmo();
        finish_test();
    end
endmodule // acsd_tb
